// ### logic/alb_device.sv
/*
 * Device end: aperiodic buffer size and block size registers, the sequential
 * data port with auto-incrementing pointer, the buffer memory, a write FIFO
 * and the end-of-transfer flag.
 * Assumes the host end on the same clock and an engine that reads the buffer.
 */
// Contract
// - buffer size register, codes 34/B4
// - buffer size resets to 0200H
// - host keeps buffer size at most 4096
// - sequential data port, codes 44/C4
// - port access always starts at address zero
// - host loads count, checks status first
// - command first, then data words accepted
// - pointer advances after each data word
// - count reached sets end flag, status
// - buffer split into equal descriptor blocks
// - block size register, codes 54/D4
// - host keeps block size multiple of 8
// - block size bits 9:0, reset zero
`default_nettype none
module alb_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic full;
    logic empty;
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign empty = (wr_q == rd_q);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_q[AW-1:0]];
    always_ff @(posedge clock) begin
        if (in_valid && !full) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (in_valid && !full) begin
                wr_q <= wr_q + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

module alb_device
    import alb_pkg::*;
#(
    parameter int WORDS = MEM_WORDS,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic arst_n,
    alb_link_if.device link,
    input wire logic eot_clear,
    input wire logic eng_re,
    input wire logic [$clog2(WORDS)-1:0] eng_addr,
    output logic [15:0] eng_rdata,
    input wire logic [BLK_IDX_W-1:0] eng_blk_idx,
    output logic [15:0] eng_blk_base,
    output logic [15:0] aperiodic_buffer_size,
    output logic [15:0] aperiodic_block_size,
    output logic status_update
);
    localparam int AW = $clog2(WORDS);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_BUF,
        ST_WR_BUF,
        ST_RD_BLK,
        ST_WR_BLK,
        ST_PORT_RD,
        ST_PORT_WR
    } alb_state_t;

    alb_state_t state_q;
    logic [15:0] mem [WORDS];
    logic [15:0] buf_size_q;
    logic [9:0] blk_size_q;
    logic [15:0] count_q;
    logic [15:0] ptr_q;
    logic [15:0] ptr_d;
    logic [15:0] drain_ptr_q;
    logic [15:0] drain_ptr_d;
    logic [15:0] ddata_q;
    logic dvalid_q;
    logic eot_q;
    logic status_q;
    logic [15:0] eng_rdata_q;
    logic [15:0] blk_base_q;
    logic push;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [15:0] fifo_out_data;
    logic port_rd_step;
    logic rd_done;
    logic drain;
    logic wr_done;
    logic [15:0] blk_read;

    assign ptr_d = ptr_q + WORD_BYTES;
    assign drain_ptr_d = drain_ptr_q + WORD_BYTES;
    assign port_rd_step = link.dat_re && (state_q == ST_PORT_RD);
    assign rd_done = port_rd_step && (ptr_d >= count_q);
    assign push = link.dat_we && (state_q == ST_PORT_WR) && fifo_in_ready;
    // engine reads take the memory first, so the fifo really stalls
    assign fifo_out_ready = !eng_re;
    assign drain = fifo_out_valid && fifo_out_ready;
    assign wr_done = drain && (drain_ptr_d >= count_q);
    assign blk_read = {6'h00, blk_size_q} & BLK_SIZE_MASK;

    alb_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .arst_n(arst_n),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(link.hdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // command decode; a new command always restarts the sequence
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
        end else if (link.cmd_we) begin
            unique case (link.hdata[7:0])
                CMD_RD_BUF_SIZE: state_q <= ST_RD_BUF;
                CMD_WR_BUF_SIZE: state_q <= ST_WR_BUF;
                CMD_RD_PORT: state_q <= ST_PORT_RD;
                CMD_WR_PORT: state_q <= ST_PORT_WR;
                CMD_RD_BLK_SIZE: state_q <= ST_RD_BLK;
                CMD_WR_BLK_SIZE: state_q <= ST_WR_BLK;
                default: state_q <= ST_IDLE;
            endcase
        end else begin
            unique case (state_q)
                ST_RD_BUF, ST_RD_BLK: begin
                    if (link.dat_re) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_WR_BUF, ST_WR_BLK: begin
                    if (link.dat_we) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_PORT_RD: begin
                    if (rd_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_PORT_WR: begin
                    if (push && (ptr_d >= count_q)) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: state_q <= ST_IDLE;
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            buf_size_q <= BUF_SIZE_RST;
            blk_size_q <= BLK_SIZE_RST[9:0];
        end else if (link.dat_we && !link.cmd_we) begin
            if (state_q == ST_WR_BUF) begin
                buf_size_q <= link.hdata;
            end
            if (state_q == ST_WR_BLK) begin
                blk_size_q <= link.hdata[9:0];
            end
        end
    end

    // port pointer: zeroed by each port command, stepped per word
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ptr_q <= PORT_START_ADDR;
            count_q <= ZERO16;
        end else if (link.cmd_we) begin
            ptr_q <= PORT_START_ADDR;
            count_q <= link.xfer_count;
        end else if (port_rd_step || push) begin
            ptr_q <= ptr_d;
        end
    end

    // drain pointer follows the fifo output into memory
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            drain_ptr_q <= PORT_START_ADDR;
        end else if (link.cmd_we && (link.hdata[7:0] == CMD_WR_PORT)) begin
            drain_ptr_q <= PORT_START_ADDR;
        end else if (drain) begin
            drain_ptr_q <= drain_ptr_d;
        end
    end

    always_ff @(posedge clock) begin
        if (drain) begin
            mem[drain_ptr_q[AW:1]] <= fifo_out_data;
        end
    end

    // every data read gets an answer one cycle later
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ddata_q <= PORT_DATA_RST;
            dvalid_q <= 1'b0;
        end else begin
            dvalid_q <= link.dat_re;
            if (link.dat_re) begin
                unique case (state_q)
                    ST_RD_BUF: ddata_q <= buf_size_q;
                    ST_RD_BLK: ddata_q <= blk_read;
                    ST_PORT_RD: ddata_q <= mem[ptr_q[AW:1]];
                    default: ddata_q <= ZERO16;
                endcase
            end
        end
    end

    // end flag: a set in the clear cycle wins
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            eot_q <= 1'b0;
            status_q <= 1'b0;
        end else begin
            status_q <= rd_done || wr_done;
            if (rd_done || wr_done) begin
                eot_q <= 1'b1;
            end else if (eot_clear) begin
                eot_q <= 1'b0;
            end
        end
    end

    // engine side: buffer reads and descriptor block base
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            eng_rdata_q <= ZERO16;
            blk_base_q <= ZERO16;
        end else begin
            if (eng_re) begin
                eng_rdata_q <= mem[eng_addr];
            end
            blk_base_q <= 16'(eng_blk_idx * blk_size_q);
        end
    end

    assign link.ddata = ddata_q;
    assign link.dvalid = dvalid_q;
    assign link.dready = fifo_in_ready;
    assign link.buf_busy = (state_q == ST_PORT_RD) || (state_q == ST_PORT_WR) || fifo_out_valid;
    assign link.eot_flag = eot_q;
    assign eng_rdata = eng_rdata_q;
    assign eng_blk_base = blk_base_q;
    assign aperiodic_buffer_size = buf_size_q;
    assign aperiodic_block_size = blk_read;
    assign status_update = status_q;
endmodule
`default_nettype wire

// ### logic/alb_host.sv
/*
 * Host driver end: turns user operations (command, data write, data read)
 * into link strobes, and refuses settings and accesses the device forbids.
 * Assumes the device end on the same clock.
 */
`default_nettype none
module alb_host
    import alb_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    alb_link_if.host link,
    input wire logic op_valid,
    input wire alb_op_t op_kind,
    input wire logic [15:0] op_data,
    output logic op_ready,
    output logic op_error,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    input wire logic [15:0] transfer_byte_counter,
    output logic eot_seen
);
    typedef enum logic [0:0] {
        H_IDLE,
        H_WAIT_RD
    } alb_hstate_t;

    alb_hstate_t state_q;
    logic cmd_we_q;
    logic dat_we_q;
    logic dat_re_q;
    logic [15:0] hdata_q;
    logic [7:0] last_cmd_q;
    logic err_q;
    logic rsp_valid_q;
    logic [15:0] rsp_data_q;
    logic take;
    logic is_port_cmd;
    logic bad_cmd;
    logic bad_wr;
    logic refuse;
    logic port_last;

    assign op_ready = (state_q == H_IDLE) && !cmd_we_q && !dat_we_q
                      && ((op_kind != ALB_OP_WR) || link.dready);
    assign take = op_valid && op_ready;
    assign is_port_cmd = (op_data[7:0] == CMD_RD_PORT) || (op_data[7:0] == CMD_WR_PORT);
    assign bad_cmd = is_port_cmd && (link.buf_busy || (transfer_byte_counter == ZERO16));
    assign bad_wr = ((last_cmd_q == CMD_WR_BUF_SIZE) && (op_data > BUF_SIZE_MAX))
                    || ((last_cmd_q == CMD_WR_BLK_SIZE)
                        && ((op_data & BLK_ALIGN_MASK) != ZERO16));
    assign refuse = ((op_kind == ALB_OP_CMD) && bad_cmd) || ((op_kind == ALB_OP_WR) && bad_wr);
    assign port_last = (last_cmd_q == CMD_WR_PORT) || (last_cmd_q == CMD_RD_PORT);

    // one strobe per accepted operation, command before data
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cmd_we_q <= 1'b0;
            dat_we_q <= 1'b0;
            dat_re_q <= 1'b0;
            hdata_q <= ZERO16;
            err_q <= 1'b0;
        end else begin
            cmd_we_q <= take && !refuse && (op_kind == ALB_OP_CMD);
            dat_we_q <= take && !refuse && (op_kind == ALB_OP_WR);
            dat_re_q <= take && (op_kind == ALB_OP_RD);
            err_q <= take && refuse;
            if (take && !refuse) begin
                hdata_q <= op_data;
            end
        end
    end

    // remembers which command the following data words belong to
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            last_cmd_q <= CMD_NONE;
        end else if (take && !refuse && (op_kind == ALB_OP_CMD)) begin
            last_cmd_q <= op_data[7:0];
        end else if (take && !refuse && (op_kind == ALB_OP_WR) && !port_last) begin
            last_cmd_q <= CMD_NONE;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= H_IDLE;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= ZERO16;
        end else begin
            rsp_valid_q <= 1'b0;
            unique case (state_q)
                H_IDLE: begin
                    if (take && (op_kind == ALB_OP_RD)) begin
                        state_q <= H_WAIT_RD;
                    end
                end
                H_WAIT_RD: begin
                    if (link.dvalid) begin
                        state_q <= H_IDLE;
                        rsp_valid_q <= 1'b1;
                        rsp_data_q <= link.ddata;
                    end
                end
            endcase
        end
    end

    assign link.cmd_we = cmd_we_q;
    assign link.dat_we = dat_we_q;
    assign link.dat_re = dat_re_q;
    assign link.hdata = hdata_q;
    assign link.xfer_count = transfer_byte_counter;
    assign op_error = err_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign eot_seen = link.eot_flag;
endmodule
`default_nettype wire

// ### logic/alb_link_if.sv
/*
 * Parallel processor I/O link between the host driver end and the device end.
 * Assumes both ends share one clock; strobes are one-cycle pulses.
 */
`default_nettype none
interface alb_link_if;
    logic cmd_we;
    logic dat_we;
    logic dat_re;
    logic [15:0] hdata;
    logic [15:0] ddata;
    logic dvalid;
    logic dready;
    logic [15:0] xfer_count;
    logic buf_busy;
    logic eot_flag;
    modport device (
        input cmd_we,
        input dat_we,
        input dat_re,
        input hdata,
        input xfer_count,
        output ddata,
        output dvalid,
        output dready,
        output buf_busy,
        output eot_flag
    );
    modport host (
        output cmd_we,
        output dat_we,
        output dat_re,
        output hdata,
        output xfer_count,
        input ddata,
        input dvalid,
        input dready,
        input buf_busy,
        input eot_flag
    );
endinterface
`default_nettype wire

// ### logic/alb_pkg.sv
/*
 * Shared constants for the aperiodic list buffer access port: command codes,
 * reset values, field masks and buffer geometry.
 * Assumes both ends and the bench import it whole.
 */
`default_nettype none
package alb_pkg;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int MEM_WORDS = 2048;
    localparam int BLK_IDX_W = 5;
    // command codes sent in the low byte of a command cycle
    localparam logic [7:0] CMD_RD_BUF_SIZE = 8'h34;
    localparam logic [7:0] CMD_WR_BUF_SIZE = 8'hB4;
    localparam logic [7:0] CMD_RD_PORT = 8'h44;
    localparam logic [7:0] CMD_WR_PORT = 8'hC4;
    localparam logic [7:0] CMD_RD_BLK_SIZE = 8'h54;
    localparam logic [7:0] CMD_WR_BLK_SIZE = 8'hD4;
    localparam logic [7:0] CMD_NONE = 8'h00;
    // register values and fields
    localparam logic [15:0] BUF_SIZE_RST = 16'h0200;
    localparam logic [15:0] BLK_SIZE_RST = 16'h0000;
    localparam logic [15:0] BLK_SIZE_MASK = 16'h03FF;
    localparam logic [15:0] PORT_DATA_RST = 16'h0000;
    localparam logic [15:0] PORT_START_ADDR = 16'h0000;
    localparam logic [15:0] BUF_SIZE_MAX = 16'h1000;
    localparam logic [15:0] BLK_ALIGN_MASK = 16'h0007;
    localparam logic [15:0] WORD_BYTES = 16'h0002;
    localparam logic [15:0] ZERO16 = 16'h0000;
    typedef enum logic [1:0] {
        ALB_OP_CMD,
        ALB_OP_WR,
        ALB_OP_RD
    } alb_op_t;
endpackage
`default_nettype wire

// ### test/alb_link_asserts.sv
/*
 * Link checker: register readback, port pointer end, data valid timing, strobes.
 * Assumes it sits beside the link interface, on the link's single clock.
 */
`default_nettype none
module alb_link_asserts
    import alb_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic cmd_we,
    input wire logic dat_we,
    input wire logic dat_re,
    input wire logic [15:0] hdata,
    input wire logic [15:0] ddata,
    input wire logic dvalid,
    input wire logic dready,
    input wire logic [15:0] xfer_count,
    input wire logic buf_busy,
    input wire logic eot_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mode_q;
    logic [15:0] cnt_q, ptr_q, size_q, blk_q;
    logic step, last, reg_step;
    assign step = (dat_re && mode_q == CMD_RD_PORT) || (dat_we && mode_q == CMD_WR_PORT);
    assign last = step && ((ptr_q + WORD_BYTES) >= cnt_q);
    assign reg_step = (dat_re || dat_we) && mode_q != CMD_RD_PORT && mode_q != CMD_WR_PORT;
    // shadow of the mode, pointer and both registers as seen on the link
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= CMD_NONE;
            cnt_q <= ZERO16;
            ptr_q <= ZERO16;
            size_q <= BUF_SIZE_RST;
            blk_q <= BLK_SIZE_RST;
        end else if (cmd_we) begin
            mode_q <= hdata[7:0];
            cnt_q <= xfer_count;
            ptr_q <= PORT_START_ADDR;
        end else begin
            if (last || reg_step) mode_q <= CMD_NONE;
            if (step) ptr_q <= ptr_q + WORD_BYTES;
            if (dat_we && mode_q == CMD_WR_BUF_SIZE) size_q <= hdata;
            if (dat_we && mode_q == CMD_WR_BLK_SIZE) blk_q <= hdata & BLK_SIZE_MASK;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence s_reg_read(logic [7:0] code);
        dat_re && mode_q == code;
    endsequence
    sequence s_final_read;
        last && mode_q == CMD_RD_PORT;
    endsequence
    a_dvalid_answer: assert property (dat_re |=> dvalid)
        else $error("read strobe not answered");
    a_dvalid_cause: assert property (dvalid |-> $past(dat_re))
        else $error("data valid without read strobe");
    a_ddata_hold: assert property (!dvalid |-> $stable(ddata))
        else $error("read data moved without data valid");
    a_size_readback: assert property (
        s_reg_read(CMD_RD_BUF_SIZE) |=> ddata == $past(size_q))
        else $error("buffer size readback wrong");
    a_blk_readback: assert property (
        s_reg_read(CMD_RD_BLK_SIZE) |=> ddata == $past(blk_q))
        else $error("block size readback wrong");
    a_eot_on_count: assert property (s_final_read |=> eot_flag)
        else $error("end flag not set at count");
    a_read_end_idle: assert property (s_final_read |=> !buf_busy)
        else $error("port still busy after final word");
    a_eot_cause: assert property ($rose(eot_flag) |-> $past(buf_busy))
        else $error("end flag rose without a transfer");
    a_port_busy: assert property (cmd_we && hdata[7:0] == CMD_WR_PORT |=> buf_busy)
        else $error("write port command left port idle");
    a_strobe_excl: assert property (cmd_we |-> !dat_we && !dat_re)
        else $error("command and data strobes together");
    a_fifo_recovers: assert property (!dready |-> ##[1:300] dready)
        else $error("write buffer never drained");
endmodule
`default_nettype wire

// ### test/tb_aperiodic_list_buffer_access.sv
/*
 * Self-checking bench: host end and device end joined by the link, driven through host ops.
 * Assumes one 25 MHz clock and the link checker beside the interface.
 */
`default_nettype none
module tb_aperiodic_list_buffer_access
    import alb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic arst_n, op_valid, eot_clear, eng_re, op_ready, op_error;
    logic rsp_valid, eot_seen, stat_upd, err;
    alb_op_t op_kind;
    logic [15:0] op_data, rsp_data, counter, eng_rdata, blk_base, buf_size, blk_size, rd;
    logic [10:0] eng_addr;
    logic [4:0] eng_blk_idx;
    int n_mismatch = 0;
    int cmp_count = 0;
    int n_stat = 0;
    alb_link_if alb_link_if_inst ();
    alb_device alb_device_inst (.clock(clock), .arst_n(arst_n), .link(alb_link_if_inst),
        .eot_clear(eot_clear), .eng_re(eng_re), .eng_addr(eng_addr), .eng_rdata(eng_rdata),
        .eng_blk_idx(eng_blk_idx), .eng_blk_base(blk_base), .aperiodic_buffer_size(buf_size),
        .aperiodic_block_size(blk_size), .status_update(stat_upd));
    alb_host alb_host_inst (.clock(clock), .arst_n(arst_n), .link(alb_link_if_inst),
        .op_valid(op_valid), .op_kind(op_kind), .op_data(op_data), .op_ready(op_ready),
        .op_error(op_error), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .transfer_byte_counter(counter), .eot_seen(eot_seen));
    alb_link_asserts alb_link_asserts_inst (.clock(clock), .arst_n(arst_n),
        .cmd_we(alb_link_if_inst.cmd_we), .dat_we(alb_link_if_inst.dat_we),
        .dat_re(alb_link_if_inst.dat_re), .hdata(alb_link_if_inst.hdata),
        .ddata(alb_link_if_inst.ddata), .dvalid(alb_link_if_inst.dvalid),
        .dready(alb_link_if_inst.dready), .xfer_count(alb_link_if_inst.xfer_count),
        .buf_busy(alb_link_if_inst.buf_busy), .eot_flag(alb_link_if_inst.eot_flag));
    initial forever #20 clock = ~clock;
    // status update pulses, one per finished port transfer
    always @(negedge clock) begin
        if (stat_upd === 1'b1) n_stat++;
    end
    task automatic summarize();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // offer one op, hold it until taken, then collect error pulse and read answer
    task automatic xfer(input alb_op_t k, input logic [15:0] d, output logic e,
        output logic [15:0] r);
        int n;
        n = 0;
        e = 1'b0;
        r = ZERO16;
        @(posedge clock);
        op_valid <= 1'b1;
        op_kind <= k;
        op_data <= d;
        @(negedge clock);
        while (op_ready !== 1'b1 && n < 200) begin
            n++;
            @(negedge clock);
        end
        chk("op_ready", 16'h0001, {15'h0000, op_ready});
        @(posedge clock);
        op_valid <= 1'b0;
        repeat (5) begin
            @(negedge clock);
            e = e | op_error;
            if (rsp_valid === 1'b1) r = rsp_data;
        end
    endtask
    task automatic cmd(input logic [7:0] code, input logic exp_err);
        xfer(ALB_OP_CMD, {8'h00, code}, err, rd);
        chk("cmd_error", {15'h0000, exp_err}, {15'h0000, err});
    endtask
    task automatic rreg(input logic [7:0] code, input logic [15:0] exp);
        cmd(code, 1'b0);
        xfer(ALB_OP_RD, ZERO16, err, rd);
        chk("reg_read", exp, rd);
    endtask
    task automatic wreg(input logic [7:0] code, input logic [15:0] v, input logic exp_err);
        cmd(code, 1'b0);
        xfer(ALB_OP_WR, v, err, rd);
        chk("wr_error", {15'h0000, exp_err}, {15'h0000, err});
    endtask
    task automatic set_count(input logic [15:0] c);
        @(posedge clock);
        counter <= c;
    endtask
    task automatic pulse_clear();
        @(posedge clock);
        eot_clear <= 1'b1;
        @(posedge clock);
        eot_clear <= 1'b0;
        @(negedge clock);
        chk("eot_clear", ZERO16, {15'h0000, eot_seen});
    endtask
    task automatic wait_eot();
        int n;
        n = 0;
        while (eot_seen !== 1'b1 && n < 100) begin
            n++;
            @(negedge clock);
        end
        chk("eot", 16'h0001, {15'h0000, eot_seen});
    endtask
    task automatic read_port(input int words, input logic [15:0] base);
        set_count(16'(words * 2));
        cmd(CMD_RD_PORT, 1'b0);
        for (int i = 0; i < words; i++) begin
            xfer(ALB_OP_RD, ZERO16, err, rd);
            chk("port_read", base + 16'(i), rd);
        end
    endtask
    initial begin
        arst_n = 1'b0;
        op_valid = 1'b0;
        op_kind = ALB_OP_CMD;
        op_data = ZERO16;
        counter = ZERO16;
        eot_clear = 1'b0;
        eng_re = 1'b0;
        eng_addr = 11'h000;
        eng_blk_idx = 5'h00;
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        rreg(CMD_RD_BUF_SIZE, BUF_SIZE_RST);
        rreg(CMD_RD_BLK_SIZE, BLK_SIZE_RST);
        wreg(CMD_WR_BUF_SIZE, BUF_SIZE_MAX, 1'b0);
        wreg(CMD_WR_BUF_SIZE, 16'h1008, 1'b1);
        rreg(CMD_RD_BUF_SIZE, 16'h1000);
        chk("size_out", 16'h1000, buf_size);
        wreg(CMD_WR_BLK_SIZE, 16'hFC48, 1'b0);
        wreg(CMD_WR_BLK_SIZE, 16'h0044, 1'b1);
        rreg(CMD_RD_BLK_SIZE, 16'h0048);
        chk("blk_out", 16'h0048, blk_size);
        @(posedge clock);
        eng_blk_idx <= 5'h03;
        repeat (2) @(negedge clock);
        chk("blk_base", 16'h00D8, blk_base);
        set_count(ZERO16);
        cmd(CMD_WR_PORT, 1'b1);
        set_count(16'h0008);
        cmd(CMD_WR_PORT, 1'b0);
        for (int i = 0; i < 4; i++) begin
            xfer(ALB_OP_WR, 16'hA000 + 16'(i), err, rd);
            if (i == 1) cmd(CMD_RD_PORT, 1'b1);
        end
        wait_eot();
        pulse_clear();
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            eng_re <= 1'b1;
            eng_addr <= 11'(i);
            @(posedge clock);
            eng_re <= 1'b0;
            @(negedge clock);
            chk("mem_word", 16'hA000 + 16'(i), eng_rdata);
        end
        read_port(3, 16'hA000);
        wait_eot();
        read_port(1, 16'hA000);
        pulse_clear();
        set_count(16'h0050);
        eng_re <= 1'b1;
        cmd(CMD_WR_PORT, 1'b0);
        for (int i = 0; i < 32; i++) xfer(ALB_OP_WR, 16'(i), err, rd);
        @(negedge clock);
        chk("fifo_full", ZERO16, {15'h0000, alb_link_if_inst.dready});
        @(posedge clock);
        eng_re <= 1'b0;
        for (int i = 32; i < 40; i++) xfer(ALB_OP_WR, 16'(i), err, rd);
        wait_eot();
        read_port(40, ZERO16);
        @(negedge clock);
        chk("status_updates", 16'h0005, 16'(n_stat));
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire
